// *** core/dmsp_core.sv ***
// Internal data memory, working-register banks, stack with debug record,
// and the paged special-register space with its three-byte page stack.
// Assumes the core issues at most one access or stack event per cycle;
// stack events take priority over a simultaneous access.
`timescale 1ns/10ps
`default_nettype none

module dmsp_core (
    input  wire logic        CLOCK,       // System clock, 20 MHz
    input  wire logic        RESETN,      // Asynchronous reset, active low
    input  wire logic        ACC_VALID,   // Data access request
    input  wire logic        ACC_WRITE,   // 1 write, 0 read
    input  wire logic [1:0]  ACC_MODE,    // dmsp_mode_t
    input  wire logic        ACC_BIT,     // Bit instruction type
    input  wire logic [7:0]  ACC_ADDR,    // Direct byte or bit address
    input  wire logic [2:0]  ACC_REG,     // Working register number
    input  wire logic [7:0]  ACC_WDATA,   // Write byte, bit value in bit 0
    input  wire logic [7:0]  PSW_IN,      // program_status_word from core
    input  wire logic        STK_PUSH,    // Push one byte
    input  wire logic        STK_POP,     // Pop one byte
    input  wire logic        STK_CALL,    // Push two bytes of return address
    input  wire logic        STK_RET,     // Pop two bytes, subroutine return
    input  wire logic        STK_RETI,    // Pop two bytes, interrupt return
    input  wire logic [15:0] STK_WDATA,   // Push byte in 7:0, call address
    input  wire logic        INT_ENTRY,   // Interrupt vectoring pulse
    input  wire logic [7:0]  INT_PAGE,    // Page of the interrupting flag
    input  wire logic [7:0]  SFR_RDATA,   // Read data from outside registers
    output logic             RD_VALID,    // Read data valid pulse
    output logic [7:0]       RD_DATA,     // Read byte, bit result in bit 0
    output logic             POP_VALID,   // Pop data valid pulse
    output logic [15:0]      POP_DATA,    // Popped byte or return address
    output logic             SFR_REQ,     // Outside register access pulse
    output logic             SFR_WE,      // Outside register write
    output logic             SFR_BITACC,  // Outside access is a bit access
    output logic [2:0]       SFR_BITSEL,  // Bit number for a bit access
    output logic [7:0]       SFR_ADDR,    // Outside register address
    output logic [7:0]       SFR_PAGE,    // Page for the access
    output logic             SFR_ALLPG,   // Address is present on all pages
    output logic [7:0]       SFR_WDATA,   // Outside register write data
    output logic [7:0]       SP_OUT,      // stack_pointer
    output logic [7:0]       PAGE_OUT,    // page_select_reg
    output logic [31:0]      DBG_RECORD,  // Stack record shift register
    output logic             DBG_OVF,     // Record overflow pulse
    output logic             DBG_UNF      // Record underflow pulse
);

    ////////////////////////////////////////////////////////////////////////
    // Storage
    logic [7:0]  ram [0:255];          // Full 256-byte data memory
    logic [7:0]  sp_reg;
    logic [7:0]  page_reg;
    logic [7:0]  second_reg;
    logic [7:0]  bottom_reg;
    logic        auto_page_enable_reg;
    logic [31:0] rec_reg;
    logic [5:0]  rec_cnt_reg;
    logic        ovf_reg;
    logic        unf_reg;
    // Read pipeline
    logic        rd_p1_reg;
    logic        rd_ext_reg;
    logic        rd_bit_reg;
    logic [2:0]  rd_bitsel_reg;
    logic [7:0]  rd_int_reg;
    logic        rd_valid_reg;
    logic [7:0]  rd_data_reg;
    logic        pop_valid_reg;
    logic [15:0] pop_data_reg;
    logic        sfr_req_reg;
    logic        sfr_we_reg;
    logic        sfr_bitacc_reg;
    logic [2:0]  sfr_bitsel_reg;
    logic [7:0]  sfr_addr_reg;
    logic        sfr_allpg_reg;
    logic [7:0]  sfr_wdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Bit address to byte address: low half maps into 0x20-0x2F
    function automatic logic [7:0] bit_byte(input logic [7:0] a);
        bit_byte = a[7] ? {a[7:3], 3'h0}
                        : dmsp_pkg::BIT_BYTE_BASE + {4'h0, a[6:3]};
    endfunction : bit_byte

    // Replace one bit of a byte
    function automatic logic [7:0] set_bit(input logic [7:0] b,
                                           input logic [2:0] n,
                                           input logic       v);
        logic [7:0] r;
        r    = b;
        r[n] = v;
        set_bit = r;
    endfunction : set_bit

    ////////////////////////////////////////////////////////////////////////
    // Address decode
    wire [1:0] bank      = {PSW_IN[dmsp_pkg::PSW_BANK_HIGH],
                            PSW_IN[dmsp_pkg::PSW_BANK_LOW]};
    wire [7:0] reg_addr  = {3'h0, bank, ACC_REG};
    wire [7:0] ptr_addr  = {3'h0, bank, 2'h0, ACC_REG[0]};
    wire       is_direct = ACC_MODE == dmsp_pkg::MODE_DIRECT;
    wire       is_ind    = ACC_MODE == dmsp_pkg::MODE_INDIRECT;
    wire       use_bit   = ACC_BIT && is_direct;
    wire [7:0] dir_addr  = use_bit ? bit_byte(ACC_ADDR) : ACC_ADDR;
    wire [2:0] bit_num   = ACC_ADDR[2:0];
    wire [7:0] byte_addr = is_ind ? ram[ptr_addr]
                         : is_direct ? dir_addr : reg_addr;
    // Bit addresses of the upper half always land on 0x?0 or 0x?8 bytes
    wire       is_sfr    = is_direct && dir_addr[7];
    wire       on_pgctl  = page_reg == dmsp_pkg::PAGE_PGCTL;
    wire       hit_sp    = is_sfr && dir_addr == dmsp_pkg::ADDR_SP;
    wire       hit_page  = is_sfr && dir_addr == dmsp_pkg::ADDR_PAGE;
    wire       hit_sec   = is_sfr && dir_addr == dmsp_pkg::ADDR_SECOND;
    wire       hit_bot   = is_sfr && dir_addr == dmsp_pkg::ADDR_BOTTOM;
    wire       hit_pgctl = is_sfr && on_pgctl && dir_addr == dmsp_pkg::ADDR_PGCTL;
    wire       hit_int   = hit_sp | hit_page | hit_sec | hit_bot | hit_pgctl;
    wire       ext_sfr   = is_sfr && !hit_int;
    wire       all_pages = dir_addr == dmsp_pkg::ADDR_PORT0
                         || dir_addr == dmsp_pkg::ADDR_PORT1
                         || dir_addr == dmsp_pkg::ADDR_PORT2
                         || dir_addr == dmsp_pkg::ADDR_PORT3;

    // Internal read value, before bit selection
    wire [7:0] int_rdata = hit_sp    ? sp_reg
                         : hit_page  ? page_reg
                         : hit_sec   ? second_reg
                         : hit_bot   ? bottom_reg
                         : hit_pgctl ? {7'h0, auto_page_enable_reg}
                         : ram[byte_addr];

    ////////////////////////////////////////////////////////////////////////
    // Stack events and record arithmetic
    wire       stk_any   = STK_PUSH | STK_POP | STK_CALL | STK_RET | STK_RETI;
    wire       acc_go    = ACC_VALID && !stk_any;
    wire       acc_wr    = acc_go && ACC_WRITE;
    wire       stk_ret2  = STK_RET | STK_RETI;
    wire [7:0] sp_inc1   = sp_reg + 8'h01;
    wire [7:0] sp_inc2   = sp_reg + 8'h02;
    wire [7:0] sp_dec1   = sp_reg - 8'h01;
    // Software writes that step the pointer by one count as push or pop
    wire       sw_sp_inc = acc_wr && hit_sp && ACC_WDATA == sp_inc1;
    wire       sw_sp_dec = acc_wr && hit_sp && ACC_WDATA == sp_dec1;
    wire [1:0] rec_in_n  = STK_CALL ? 2'h2 : (STK_PUSH | sw_sp_inc) ? 2'h1 : 2'h0;
    wire [1:0] rec_out_n = stk_ret2 ? 2'h2 : (STK_POP | sw_sp_dec) ? 2'h1 : 2'h0;
    wire [6:0] rec_sum   = {1'b0, rec_cnt_reg} + {5'h0, rec_in_n};
    wire       rec_over  = rec_sum > {1'b0, dmsp_pkg::REC_FULL};
    wire       rec_under = rec_cnt_reg < {4'h0, rec_out_n};

    ////////////////////////////////////////////////////////////////////////
    // Data memory writes: stack traffic or data access
    always_ff @(posedge CLOCK) begin
        if (STK_PUSH) begin
            ram[sp_inc1] <= STK_WDATA[7:0];
        end else if (STK_CALL) begin
            ram[sp_inc1] <= STK_WDATA[7:0];
            ram[sp_inc2] <= STK_WDATA[15:8];
        end else if (acc_wr && !is_sfr) begin
            ram[byte_addr] <= use_bit ? set_bit(ram[byte_addr], bit_num, ACC_WDATA[0])
                                      : ACC_WDATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stack pointer; pointer wraps within the 256-byte memory
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            sp_reg <= dmsp_pkg::SP_RESET;
        end else if (STK_PUSH) begin
            sp_reg <= sp_inc1;
        end else if (STK_CALL) begin
            sp_reg <= sp_inc2;
        end else if (STK_POP) begin
            sp_reg <= sp_dec1;
        end else if (stk_ret2) begin
            sp_reg <= sp_reg - 8'h02;
        end else if (acc_wr && hit_sp) begin
            sp_reg <= ACC_WDATA;
        end
    end

    // Popped data, read before the pointer moves
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            pop_valid_reg <= 1'b0;
            pop_data_reg  <= 16'h0000;
        end else begin
            pop_valid_reg <= STK_POP | stk_ret2;
            if (STK_POP) begin
                pop_data_reg <= {8'h00, ram[sp_reg]};
            end else if (stk_ret2) begin
                pop_data_reg <= {ram[sp_reg], ram[sp_dec1]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Debug stack record; saturates its count so depth stays meaningful
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            rec_reg     <= 32'h00000000;
            rec_cnt_reg <= 6'h00;
            ovf_reg     <= 1'b0;
            unf_reg     <= 1'b0;
        end else begin
            ovf_reg <= rec_in_n != 2'h0 && rec_over;
            unf_reg <= rec_out_n != 2'h0 && rec_under;
            if (rec_in_n == 2'h2) begin
                rec_reg     <= {rec_reg[29:0], 2'h3};
                rec_cnt_reg <= rec_over ? dmsp_pkg::REC_FULL : rec_sum[5:0];
            end else if (rec_in_n == 2'h1) begin
                rec_reg     <= {rec_reg[30:0], 1'b0};
                rec_cnt_reg <= rec_over ? dmsp_pkg::REC_FULL : rec_sum[5:0];
            end else if (rec_out_n == 2'h2) begin
                rec_reg     <= {2'h0, rec_reg[31:2]};
                rec_cnt_reg <= rec_under ? 6'h00 : rec_cnt_reg - 6'h02;
            end else if (rec_out_n == 2'h1) begin
                rec_reg     <= {1'b0, rec_reg[31:1]};
                rec_cnt_reg <= rec_under ? 6'h00 : rec_cnt_reg - 6'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Page register and page stack; hardware shift beats a software write
    // in the same cycle so no interrupt context is lost
    wire do_push = INT_ENTRY && auto_page_enable_reg;
    wire do_pop  = STK_RETI && auto_page_enable_reg;

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            page_reg   <= dmsp_pkg::PAGE_RESET;
            second_reg <= dmsp_pkg::PAGE_RESET;
            bottom_reg <= dmsp_pkg::PAGE_RESET;
        end else if (do_push) begin
            second_reg <= page_reg;
            bottom_reg <= second_reg;
            page_reg   <= INT_PAGE;
        end else if (do_pop) begin
            page_reg   <= second_reg;
            second_reg <= bottom_reg;
            bottom_reg <= dmsp_pkg::BOTTOM_EMPTY;
        end else if (acc_wr) begin
            if (hit_page) begin
                page_reg <= ACC_WDATA;
            end
            if (hit_sec) begin
                second_reg <= ACC_WDATA;
            end
            if (hit_bot) begin
                bottom_reg <= ACC_WDATA;
            end
        end
    end

    // Page control register
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            auto_page_enable_reg <= dmsp_pkg::PGCTL_RESET[dmsp_pkg::PGCTL_AUTO_BIT];
        end else if (acc_wr && hit_pgctl) begin
            auto_page_enable_reg <= ACC_WDATA[dmsp_pkg::PGCTL_AUTO_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outside register strobe, registered one cycle after the request
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            sfr_req_reg    <= 1'b0;
            sfr_we_reg     <= 1'b0;
            sfr_bitacc_reg <= 1'b0;
            sfr_bitsel_reg <= 3'h0;
            sfr_addr_reg   <= 8'h00;
            sfr_allpg_reg  <= 1'b0;
            sfr_wdata_reg  <= 8'h00;
        end else begin
            sfr_req_reg <= acc_go && ext_sfr;
            sfr_we_reg  <= acc_wr && ext_sfr;
            if (acc_go && ext_sfr) begin
                sfr_bitacc_reg <= use_bit;
                sfr_bitsel_reg <= bit_num;
                sfr_addr_reg   <= dir_addr;
                sfr_allpg_reg  <= all_pages;
                sfr_wdata_reg  <= ACC_WDATA;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read pipeline: both paths answer two cycles after the request
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            rd_p1_reg     <= 1'b0;
            rd_ext_reg    <= 1'b0;
            rd_bit_reg    <= 1'b0;
            rd_bitsel_reg <= 3'h0;
            rd_int_reg    <= 8'h00;
        end else begin
            rd_p1_reg <= acc_go && !ACC_WRITE;
            if (acc_go && !ACC_WRITE) begin
                rd_ext_reg    <= ext_sfr;
                rd_bit_reg    <= use_bit;
                rd_bitsel_reg <= bit_num;
                rd_int_reg    <= int_rdata;
            end
        end
    end

    wire [7:0] rd_byte = rd_ext_reg ? SFR_RDATA : rd_int_reg;

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            rd_valid_reg <= 1'b0;
            rd_data_reg  <= 8'h00;
        end else begin
            rd_valid_reg <= rd_p1_reg;
            if (rd_p1_reg) begin
                rd_data_reg <= rd_bit_reg ? {7'h0, rd_byte[rd_bitsel_reg]} : rd_byte;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from flip-flops
    assign RD_VALID   = rd_valid_reg;
    assign RD_DATA    = rd_data_reg;
    assign POP_VALID  = pop_valid_reg;
    assign POP_DATA   = pop_data_reg;
    assign SFR_REQ    = sfr_req_reg;
    assign SFR_WE     = sfr_we_reg;
    assign SFR_BITACC = sfr_bitacc_reg;
    assign SFR_BITSEL = sfr_bitsel_reg;
    assign SFR_ADDR   = sfr_addr_reg;
    assign SFR_PAGE   = page_reg;
    assign SFR_ALLPG  = sfr_allpg_reg;
    assign SFR_WDATA  = sfr_wdata_reg;
    assign SP_OUT     = sp_reg;
    assign PAGE_OUT   = page_reg;
    assign DBG_RECORD = rec_reg;
    assign DBG_OVF    = ovf_reg;
    assign DBG_UNF    = unf_reg;

endmodule : dmsp_core

`default_nettype wire

// *** core/dmsp_pkg.sv ***
// Constants for the data-memory and special-register paging block.
// Assumes a single system clock and one access or stack event per cycle.
package dmsp_pkg;
    // Data memory layout
    localparam logic [7:0] BIT_BYTE_BASE  = 8'h20; // First bit-addressable byte
    localparam logic [7:0] SFR_BASE       = 8'h80; // Direct addresses from here are SFRs
    // Special-register offsets
    localparam logic [7:0] ADDR_SP        = 8'h81; // stack_pointer, all pages
    localparam logic [7:0] ADDR_PAGE      = 8'h84; // page_select_reg, all pages
    localparam logic [7:0] ADDR_SECOND    = 8'h85; // page_stack_second, all pages
    localparam logic [7:0] ADDR_BOTTOM    = 8'h86; // page_stack_bottom, all pages
    localparam logic [7:0] ADDR_PGCTL     = 8'h96; // page_control_reg
    localparam logic [7:0] PAGE_PGCTL     = 8'h0f; // Page holding page_control_reg
    // Port data registers present on every page
    localparam logic [7:0] ADDR_PORT0     = 8'h80;
    localparam logic [7:0] ADDR_PORT1     = 8'h90;
    localparam logic [7:0] ADDR_PORT2     = 8'ha0;
    localparam logic [7:0] ADDR_PORT3     = 8'hb0;
    // Program status word bank select fields
    localparam int         PSW_BANK_LOW   = 3;
    localparam int         PSW_BANK_HIGH  = 4;
    // Auto paging enable bit in page_control_reg
    localparam int         PGCTL_AUTO_BIT = 0;
    // Reset values
    localparam logic [7:0] SP_RESET       = 8'h07;
    localparam logic [7:0] PAGE_RESET     = 8'h00;
    localparam logic [7:0] PGCTL_RESET    = 8'h01;
    localparam logic [7:0] BOTTOM_EMPTY   = 8'h00; // Bottom byte after a pop
    // Stack record
    localparam int         REC_BITS       = 32;
    localparam logic [5:0] REC_FULL       = 6'h20;
    // Access modes
    typedef enum logic [1:0] {
        MODE_DIRECT   = 2'h0,
        MODE_INDIRECT = 2'h1,
        MODE_REGISTER = 2'h2
    } dmsp_mode_t;
endpackage : dmsp_pkg

// *** tb/data_memory_sfr_paging_tb_top.sv ***
// Self-checking bench for the data-memory and paging block.
// Assumes the outside register model answers in the request cycle.
`timescale 1ns/10ps
`default_nettype none
module data_memory_sfr_paging_tb_top;
    logic        clock = 1'b0, resetn = 1'b0, av = 1'b0, aw = 1'b0, ab = 1'b0, ie = 1'b0;
    logic        rdv, sreq, sall, ovf, unf, ovf_seen = 1'b0, unf_seen = 1'b0;
    logic [1:0]  am = 2'h0;
    logic [2:0]  ar = 3'h0;
    logic [4:0]  stk = 5'h00;
    logic [7:0]  aa = 8'h00, wd = 8'h00, program_status_word = 8'h00, ip = 8'h00, d, srd, rdd, sp, pg, sa, spg;
    logic [15:0] swd = 16'h0000, popd, a16;
    logic [31:0] rec;
    int          errors = 0, total_checks = 0, cycles = 0;
    dmsp_core u_dmsp_core (.CLOCK(clock), .RESETN(resetn), .ACC_VALID(av), .ACC_WRITE(aw),
        .ACC_MODE(am), .ACC_BIT(ab), .ACC_ADDR(aa), .ACC_REG(ar), .ACC_WDATA(wd), .PSW_IN(program_status_word),
        .STK_PUSH(stk[0]), .STK_POP(stk[1]), .STK_CALL(stk[2]), .STK_RET(stk[3]),
        .STK_RETI(stk[4]), .STK_WDATA(swd), .INT_ENTRY(ie), .INT_PAGE(ip), .SFR_RDATA(srd),
        .RD_VALID(rdv), .RD_DATA(rdd), .POP_VALID(), .POP_DATA(popd), .SFR_REQ(sreq),
        .SFR_WE(), .SFR_BITACC(), .SFR_BITSEL(), .SFR_ADDR(sa), .SFR_PAGE(spg),
        .SFR_ALLPG(sall), .SFR_WDATA(), .SP_OUT(sp), .PAGE_OUT(pg), .DBG_RECORD(rec),
        .DBG_OVF(ovf), .DBG_UNF(unf));
    dmsp_sfr_model u_dmsp_sfr_model (.req(sreq), .allpg(sall), .addr(sa), .page(spg),
        .rdata(srd));
    // Clock, record flag monitor and hang limit
    initial forever #25 clock = ~clock;
    always @(posedge clock) begin
        ovf_seen <= ovf_seen | ovf;
        unf_seen <= unf_seen | unf;
        cycles++;
        if (cycles == 20000) begin
            errors++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // One access pulse; ACC_REG rides on the low address bits to save a port of the task
    task automatic acc(input logic w, input logic [1:0] m, input logic b, input logic [7:0] a,
                       input logic [7:0] v);
        @(negedge clock);
        {av, aw, am, ab, aa, ar, wd} = {1'b1, w, m, b, a, a[2:0], v};
        @(negedge clock);
        av = 1'b0;
        @(negedge clock); // A read answer stands now, one edge after the request drops
    endtask : acc
    task automatic rd(input logic [1:0] m, input logic b, input logic [7:0] a,
                      input logic [7:0] e);
        acc(1'b0, m, b, a, 8'h00);
        check({rdv, rdd}, {1'b1, e});
    endtask : rd
    task automatic st(input int k, input logic [15:0] v);
        @(negedge clock);
        stk = 5'h01 << k;
        swd = v;
        @(negedge clock);
        stk = 5'h00;
    endtask : st
    task automatic intr(input logic [7:0] p);
        @(negedge clock);
        ie = 1'b1;
        ip = p;
        @(negedge clock);
        ie = 1'b0;
    endtask : intr
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(48680));
        repeat (6) @(negedge clock);
        resetn = 1'b1;
        rd(2'h0, 1'b0, 8'h81, 8'h07);
        rd(2'h0, 1'b0, 8'h85, 8'h00);
        rd(2'h0, 1'b0, 8'h86, 8'h00);
        $display("reset test done");
        for (int bk = 0; bk < 4; bk++) begin
            program_status_word = {3'h0, 2'(bk), 3'h0};
            d = 8'($urandom);
            acc(1'b1, 2'h2, 1'b0, 8'h05, d);
            rd(2'h0, 1'b0, 8'(bk * 8 + 5), d);
            acc(1'b1, 2'h2, 1'b0, 8'h01, 8'h30 + 8'(bk));
            acc(1'b1, 2'h0, 1'b0, 8'h30 + 8'(bk), ~d);
            rd(2'h1, 1'b0, 8'h01, ~d);
        end
        program_status_word = 8'h00;
        $display("bank test done");
        acc(1'b1, 2'h0, 1'b0, 8'h22, 8'h00);
        acc(1'b1, 2'h0, 1'b0, 8'h2f, 8'h00);
        acc(1'b1, 2'h0, 1'b0, 8'h13, 8'ha4);
        acc(1'b1, 2'h0, 1'b1, 8'h13, 8'h01);
        acc(1'b1, 2'h0, 1'b1, 8'h7f, 8'h01);
        rd(2'h0, 1'b0, 8'h22, 8'h08);
        rd(2'h0, 1'b0, 8'h2f, 8'h80);
        rd(2'h0, 1'b1, 8'h13, 8'h01);
        rd(2'h0, 1'b0, 8'h13, 8'ha4);
        $display("bit test done");
        d = 8'($urandom);
        a16 = 16'($urandom);
        st(0, {8'h00, d});
        check(sp, 8'h08);
        rd(2'h0, 1'b0, 8'h08, d);
        st(2, a16);
        check(rec[2:0], 3'h3);
        acc(1'b1, 2'h0, 1'b0, 8'h81, 8'h0b);
        check(rec[2:0], 3'h6);
        acc(1'b1, 2'h0, 1'b0, 8'h81, 8'h0a);
        check(rec[2:0], 3'h3);
        st(3, 16'h0000);
        @(negedge clock);
        check(popd, a16);
        st(1, 16'h0000);
        for (int i = 0; i < 16; i++) st(2, 16'($urandom));
        check(ovf_seen, 1'b0);
        st(0, 16'h0000);
        repeat (2) @(negedge clock);
        check(ovf_seen, 1'b1);
        for (int i = 0; i < 16; i++) st(3, 16'h0000);
        check(unf_seen, 1'b0);
        st(1, 16'h0000);
        repeat (2) @(negedge clock);
        check(unf_seen, 1'b1);
        acc(1'b1, 2'h0, 1'b0, 8'h81, 8'hfe);
        st(0, {8'h00, d});
        acc(1'b1, 2'h2, 1'b0, 8'h00, 8'hff);
        rd(2'h1, 1'b0, 8'h00, d);
        $display("stack test done");
        acc(1'b1, 2'h0, 1'b0, 8'h84, 8'h03);
        rd(2'h0, 1'b0, 8'h90, 8'h90);
        rd(2'h0, 1'b0, 8'h99, 8'h9a);
        acc(1'b1, 2'h0, 1'b0, 8'h99, 8'($urandom));
        acc(1'b0, 2'h0, 1'b1, 8'h8b, 8'h00);
        acc(1'b1, 2'h0, 1'b0, 8'h84, 8'h0f);
        rd(2'h0, 1'b0, 8'h96, 8'h01);
        intr(8'h02);
        check(pg, 8'h02);
        acc(1'b1, 2'h0, 1'b0, 8'h86, 8'h55);
        check(pg, 8'h02);
        rd(2'h0, 1'b0, 8'h85, 8'h0f);
        intr(8'h00);
        rd(2'h0, 1'b0, 8'h86, 8'h0f);
        st(4, 16'h0000);
        check(pg, 8'h02);
        rd(2'h0, 1'b0, 8'h86, 8'h00);
        st(4, 16'h0000);
        check(pg, 8'h0f);
        acc(1'b1, 2'h0, 1'b0, 8'h96, 8'h00);
        intr(8'h01);
        check(pg, 8'h0f);
        $display("page test done");
        wrap_up();
    end
endmodule : data_memory_sfr_paging_tb_top
`default_nettype wire

// *** tb/dmsp_core_properties.sv ***
// Concurrent checks on the paging block's ports.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
module dmsp_core_chk (
    input wire logic        CLOCK,      // Clock
    input wire logic        RESETN,     // Reset, low
    input wire logic        ACC_VALID,  // Access
    input wire logic        ACC_WRITE,  // Write
    input wire logic [1:0]  ACC_MODE,   // Mode
    input wire logic        ACC_BIT,    // Bit type
    input wire logic [7:0]  ACC_ADDR,   // Address
    input wire logic [7:0]  ACC_WDATA,  // Write byte
    input wire logic        POP_VALID,  // Pop answer
    input wire logic        SFR_WE,     // Outside write
    input wire logic [7:0]  SFR_WDATA,  // Outside data
    input wire logic        STK_PUSH,   // Push
    input wire logic        STK_POP,    // Pop
    input wire logic        STK_CALL,   // Call
    input wire logic        STK_RET,    // Return
    input wire logic        STK_RETI,   // Interrupt return
    input wire logic        RD_VALID,   // Read answer
    input wire logic        SFR_REQ,    // Outside access
    input wire logic        SFR_BITACC, // Outside bit access
    input wire logic [2:0]  SFR_BITSEL, // Bit number
    input wire logic [7:0]  SFR_ADDR,   // Outside address
    input wire logic [7:0]  SP_OUT,     // Stack pointer
    input wire logic [7:0]  PAGE_OUT,   // Page register
    input wire logic [31:0] DBG_RECORD  // Stack record
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESETN);
    // An access only counts when no stack event takes the cycle
    wire logic stk  = STK_PUSH | STK_POP | STK_CALL | STK_RET | STK_RETI;
    wire logic take = ACC_VALID & ~stk;
    wire logic hi   = take & (ACC_MODE == 2'h0) & ACC_ADDR[7];
    wire logic ext  = hi & ~ACC_BIT & !(ACC_ADDR inside {8'h81, 8'h84, 8'h85, 8'h86, 8'h96});
    sequence s_rd; take & ~ACC_WRITE; endsequence
    sequence s_ind; take & (ACC_MODE == 2'h1); endsequence
    property p_rd_lat; s_rd |-> ##2 RD_VALID; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
    property p_ext; ext |=> SFR_REQ && SFR_ADDR == $past(ACC_ADDR); endproperty
    a_ext: assert property (p_ext) else $error("direct high access not routed");
    property p_ind; s_ind |=> !SFR_REQ; endproperty
    a_ind: assert property (p_ind) else $error("indirect access left memory");
    property p_bit;
        hi & ACC_BIT |=> SFR_REQ && SFR_BITACC && SFR_ADDR == ($past(ACC_ADDR) & 8'hf8)
            && SFR_BITSEL == 3'($past(ACC_ADDR));
    endproperty
    a_bit: assert property (p_bit) else $error("bit access mapped wrong");
    property p_push; STK_PUSH |=> SP_OUT == $past(SP_OUT) + 8'h01
        && DBG_RECORD == ($past(DBG_RECORD) << 1); endproperty
    a_push: assert property (p_push) else $error("push step wrong");
    property p_call; STK_CALL |=> SP_OUT == $past(SP_OUT) + 8'h02
        && DBG_RECORD == (($past(DBG_RECORD) << 2) | 32'h3); endproperty
    a_call: assert property (p_call) else $error("call step wrong");
    property p_pop; STK_POP |=> SP_OUT == $past(SP_OUT) - 8'h01
        && DBG_RECORD == ($past(DBG_RECORD) >> 1); endproperty
    a_pop: assert property (p_pop) else $error("pop step wrong");
    property p_ret; STK_RET |=> SP_OUT == $past(SP_OUT) - 8'h02
        && DBG_RECORD == ($past(DBG_RECORD) >> 2); endproperty
    a_ret: assert property (p_ret) else $error("return step wrong");
    property p_we; ext |=> SFR_WE == $past(ACC_WRITE) && SFR_WDATA == $past(ACC_WDATA);
    endproperty
    a_we: assert property (p_we) else $error("outside write wrong");
    property p_popv; STK_POP | STK_RET | STK_RETI |=> POP_VALID; endproperty
    a_popv: assert property (p_popv) else $error("pop answer missing");
    property p_rst; $rose(RESETN) |-> SP_OUT == 8'h07 && PAGE_OUT == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("reset values wrong");
endmodule : dmsp_core_chk
bind dmsp_core dmsp_core_chk u_chk (.CLOCK(CLOCK), .RESETN(RESETN), .ACC_VALID(ACC_VALID),
    .ACC_WRITE(ACC_WRITE), .ACC_MODE(ACC_MODE), .ACC_BIT(ACC_BIT), .ACC_ADDR(ACC_ADDR),
    .STK_PUSH(STK_PUSH), .STK_POP(STK_POP), .STK_CALL(STK_CALL), .STK_RET(STK_RET),
    .STK_RETI(STK_RETI), .RD_VALID(RD_VALID), .SFR_REQ(SFR_REQ), .SFR_BITACC(SFR_BITACC),
    .SFR_BITSEL(SFR_BITSEL), .SFR_ADDR(SFR_ADDR), .SP_OUT(SP_OUT), .PAGE_OUT(PAGE_OUT),
    .DBG_RECORD(DBG_RECORD), .ACC_WDATA(ACC_WDATA), .POP_VALID(POP_VALID), .SFR_WE(SFR_WE),
    .SFR_WDATA(SFR_WDATA));
`default_nettype wire

// *** tb/dmsp_sfr_model.sv ***
// Outside special-register space answering each request of the block.
// Assumes the block holds address and page steady while it asks.
`timescale 1ns/10ps
`default_nettype none
module dmsp_sfr_model (
    input  wire logic       req,   // Access pulse
    input  wire logic       allpg, // Register present on all pages
    input  wire logic [7:0] addr,  // Register address
    input  wire logic [7:0] page,  // Current page
    output logic      [7:0] rdata  // Read data
);
    // Data stands only while asked; otherwise the inverse, so no stale value passes
    wire logic [7:0] val = allpg ? addr : addr ^ page;
    assign rdata = req ? val : ~val;
endmodule : dmsp_sfr_model
`default_nettype wire
